// file: logic/scrs_pkg.sv
// constants for the strap clock ratio select block
package scrs_pkg;
   // platform ratio strap codes
   localparam logic [3:0] SCRS_PLAT_16 = 4'h0;
   localparam logic [3:0] SCRS_PLAT_3  = 4'h3;
   localparam logic [3:0] SCRS_PLAT_4  = 4'h4;
   localparam logic [3:0] SCRS_PLAT_5  = 4'h5;
   localparam logic [3:0] SCRS_PLAT_6  = 4'h6;
   localparam logic [3:0] SCRS_PLAT_8  = 4'h8;
   localparam logic [3:0] SCRS_PLAT_9  = 4'h9;
   localparam logic [3:0] SCRS_PLAT_10 = 4'hA;
   localparam logic [3:0] SCRS_PLAT_12 = 4'hC;
   // core ratio strap codes, ratio in half steps
   localparam logic [2:0] SCRS_CORE_8H = 3'h0;
   localparam logic [2:0] SCRS_CORE_3H = 3'h3;
   localparam logic [2:0] SCRS_CORE_4H = 3'h4;
   localparam logic [2:0] SCRS_CORE_5H = 3'h5;
   localparam logic [2:0] SCRS_CORE_6H = 3'h6;
   localparam logic [2:0] SCRS_CORE_7H = 3'h7;
   // security ratio values
   localparam logic [1:0] SCRS_SEC_2   = 2'h2;
   localparam logic [1:0] SCRS_SEC_3   = 2'h3;
   localparam logic [1:0] SCRS_SEC_DFLT = SCRS_SEC_3;
   // memory clock is platform divided by this
   localparam logic [1:0] SCRS_MEM_DIV = 2'h2;
   // cycles after reset release before straps are taken
   localparam logic [1:0] SCRS_SYNC_CYC = 2'h2;
endpackage : scrs_pkg

// file: logic/scrs_half_div.sv
// divider giving a one-cycle enable at half the input rate
`timescale 1ns/100ps
module scrs_half_div
   import scrs_pkg::*;
(
   // clock and reset
   input  wire logic clock_in,
   input  wire logic rst_n_in,
   // control
   input  wire logic run_in,
   // enable out
   output logic      tick_out
);
   logic [1:0] count;
   wire  [1:0] next_count = (count == SCRS_MEM_DIV - 2'h1) ? 2'h0 : count + 2'h1;

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count    <= 2'h0;
         tick_out <= 1'b0;
      end else if (run_in) begin
         count    <= next_count;
         tick_out <= (count == SCRS_MEM_DIV - 2'h1);
      end else begin
         count    <= 2'h0;
         tick_out <= 1'b0;
      end
   end
endmodule : scrs_half_div

// file: logic/scrs_strap_select.sv
// strap sampling and clock ratio decode
`timescale 1ns/100ps
// Functional notes
// - platform ratio decoded from four-bit strap
// - memory clock is half platform clock
// - core ratio decoded from three-bit strap
// - security strap picks 2:1 or 3:1
// - security ratio defaults to 3:1
module scrs_strap_select
   import scrs_pkg::*;
(
   // clock and reset
   input  wire logic       clock_in,
   input  wire logic       rst_n_in,
   // strap pins
   input  wire logic [3:0] platform_ratio_strap_in,
   input  wire logic       core_ratio_strap_bit2_in,
   input  wire logic       core_ratio_strap_bit1_in,
   input  wire logic       core_ratio_strap_bit0_in,
   input  wire logic       security_ratio_strap_in,
   // decoded ratios
   output logic [4:0]      platform_ratio_out,
   output logic            platform_reserved_out,
   output logic [3:0]      core_ratio_half_out,
   output logic            core_reserved_out,
   output logic [1:0]      security_ratio_out,
   output logic            ratios_valid_out,
   // memory clock enable
   output logic            mem_clock_tick_out
);
   logic [3:0] plat_meta;
   logic [3:0] plat_sync;
   logic [3:0] sec_core_meta;
   logic [3:0] sec_core_sync;
   logic [1:0] wait_count;
   logic       latched;

   // platform code to ratio, zero when reserved
   function automatic logic [4:0] scrs_plat_ratio(input logic [3:0] code);
      case (code)
         SCRS_PLAT_16: scrs_plat_ratio = 5'h10;
         SCRS_PLAT_3:  scrs_plat_ratio = 5'h03;
         SCRS_PLAT_4:  scrs_plat_ratio = 5'h04;
         SCRS_PLAT_5:  scrs_plat_ratio = 5'h05;
         SCRS_PLAT_6:  scrs_plat_ratio = 5'h06;
         SCRS_PLAT_8:  scrs_plat_ratio = 5'h08;
         SCRS_PLAT_9:  scrs_plat_ratio = 5'h09;
         SCRS_PLAT_10: scrs_plat_ratio = 5'h0A;
         SCRS_PLAT_12: scrs_plat_ratio = 5'h0C;
         default:      scrs_plat_ratio = 5'h00;
      endcase
   endfunction : scrs_plat_ratio

   // core code to ratio in halves, zero when reserved
   function automatic logic [3:0] scrs_core_ratio(input logic [2:0] code);
      case (code)
         SCRS_CORE_8H: scrs_core_ratio = 4'h8;
         SCRS_CORE_3H: scrs_core_ratio = 4'h3;
         SCRS_CORE_4H: scrs_core_ratio = 4'h4;
         SCRS_CORE_5H: scrs_core_ratio = 4'h5;
         SCRS_CORE_6H: scrs_core_ratio = 4'h6;
         SCRS_CORE_7H: scrs_core_ratio = 4'h7;
         default:      scrs_core_ratio = 4'h0;
      endcase
   endfunction : scrs_core_ratio

   wire [4:0] dec_plat = scrs_plat_ratio(plat_sync);
   wire [3:0] dec_core = scrs_core_ratio(sec_core_sync[2:0]);
   wire [1:0] dec_sec  = sec_core_sync[3] ? SCRS_SEC_3 : SCRS_SEC_2;
   wire       take_now = !latched && (wait_count == SCRS_SYNC_CYC);

   // two-stage synchronisers for the strap pins
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         plat_meta     <= 4'h0;
         plat_sync     <= 4'h0;
         sec_core_meta <= 4'h0;
         sec_core_sync <= 4'h0;
      end else begin
         plat_meta     <= platform_ratio_strap_in;
         plat_sync     <= plat_meta;
         sec_core_meta <= {security_ratio_strap_in, core_ratio_strap_bit2_in,
                           core_ratio_strap_bit1_in, core_ratio_strap_bit0_in};
         sec_core_sync <= sec_core_meta;
      end
   end

   // wait for synchronisers to fill, then take once
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wait_count <= 2'h0;
         latched    <= 1'b0;
      end else begin
         if (wait_count != SCRS_SYNC_CYC) begin
            wait_count <= wait_count + 2'h1;
         end
         if (take_now) begin
            latched <= 1'b1;
         end
      end
   end

   // ratio holding registers, loaded once per reset
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         platform_ratio_out    <= 5'h00;
         platform_reserved_out <= 1'b0;
         core_ratio_half_out   <= 4'h0;
         core_reserved_out     <= 1'b0;
         security_ratio_out    <= SCRS_SEC_DFLT;
         ratios_valid_out      <= 1'b0;
      end else if (take_now) begin
         platform_ratio_out    <= dec_plat;
         platform_reserved_out <= (dec_plat == 5'h00);
         core_ratio_half_out   <= dec_core;
         core_reserved_out     <= (dec_core == 4'h0);
         security_ratio_out    <= dec_sec;
         ratios_valid_out      <= 1'b1;
      end
   end

   // memory clock runs at half platform rate
   scrs_half_div u_mem_div (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .run_in   (ratios_valid_out),
      .tick_out (mem_clock_tick_out)
   );
endmodule : scrs_strap_select

// file: verif/scrs_strap_assertions.sv
// checker for the strap ratio outputs
`timescale 1ns/100ps
module scrs_strap_assertions (
   input wire logic       clock_in,
   input wire logic       rst_n_in,
   input wire logic [4:0] platform_ratio_out,
   input wire logic       platform_reserved_out,
   input wire logic [3:0] core_ratio_half_out,
   input wire logic       core_reserved_out,
   input wire logic [1:0] security_ratio_out,
   input wire logic       ratios_valid_out,
   input wire logic       mem_clock_tick_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   sequence tick_pair_s;
      !mem_clock_tick_out ##1 mem_clock_tick_out;
   endsequence
   valid_hold_a: assert property (ratios_valid_out |=> ratios_valid_out)
      else $error("valid dropped");
   ratio_hold_a: assert property (ratios_valid_out |=> $stable(platform_ratio_out)
      && $stable(core_ratio_half_out) && $stable(security_ratio_out))
      else $error("ratio moved");
   plat_flag_a: assert property (ratios_valid_out |->
      platform_reserved_out == (platform_ratio_out == 5'h00)) else $error("plat flag");
   core_flag_a: assert property (ratios_valid_out |->
      core_reserved_out == (core_ratio_half_out == 4'h0)) else $error("core flag");
   sec_range_a: assert property (ratios_valid_out |->
      security_ratio_out inside {2'h2, 2'h3}) else $error("sec ratio");
   tick_gap_a: assert property (mem_clock_tick_out |=> tick_pair_s)
      else $error("tick not half rate");
   tick_idle_a: assert property (!ratios_valid_out |-> !mem_clock_tick_out)
      else $error("tick before valid");
   tick_start_a: assert property ($rose(ratios_valid_out) |-> ##[1:2] mem_clock_tick_out)
      else $error("tick late");
endmodule : scrs_strap_assertions

// file: verif/scrs_board_straps.sv
// board strap resistors and later shared pin traffic
`timescale 1ns/100ps
module scrs_board_straps #(
   parameter int REF_MHZ   = 66,
   parameter int GRADE_MHZ = 1067
) (
   // control
   input  wire logic       hold_in,
   input  wire logic [7:0] code_in,
   input  wire logic [7:0] noise_in,
   // strap pins
   output logic [7:0]      pins_out,
   // board side limits on the chosen straps
   output logic            legal_out,
   output logic            pci_clock_needed_out,
   output logic [7:0]      eth_fifo_max_out
);
   int plat_x, core_h, plat_mhz, core_mhz;

   assign pins_out = hold_in ? code_in : noise_in;

   // what the board must keep for a strap setting to be usable
   always_comb begin
      case (code_in[7:4])
         4'h0: plat_x = 16;
         4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'hA, 4'hC: plat_x = int'(code_in[7:4]);
         default: plat_x = 0;
      endcase
      case (code_in[3:1])
         3'h0: core_h = 8;
         3'h1, 3'h2: core_h = 0;
         default: core_h = int'(code_in[3:1]);
      endcase
      plat_mhz = plat_x * REF_MHZ;
      core_mhz = plat_mhz * core_h / 2;
      legal_out = (plat_x != 0) && (core_h != 0)
         && (plat_mhz >= 333) && (core_mhz >= 667)
         && (core_mhz <= GRADE_MHZ)
         && (plat_mhz / 2 >= 166) && (plat_mhz / 2 <= 266)
         && (code_in[0] || (plat_mhz <= 400));
      pci_clock_needed_out = (REF_MHZ < 33) || (REF_MHZ > 66);
      eth_fifo_max_out = (plat_mhz >= 533) ? 8'h7E : 8'h5E;
   end
endmodule : scrs_board_straps

// file: verif/strap_clock_ratio_select_tb_top.sv
// bench for strap ratio decode and latch
`timescale 1ns/100ps
module strap_clock_ratio_select_tb_top;
   import scrs_pkg::*;
   logic       clock_in = 0, rst_n_in = 0, hold = 1, pres, cres, vld, tick;
   logic [7:0] code = 8'h00, noise = 8'h00, pins, t;
   logic [4:0] plat;
   logic [3:0] core;
   logic [1:0] sec;
   logic       legal, pci_need;
   logic [7:0] eth_max;
   logic [31:0] rng = 32'hE142;
   int         fail_count = 0, compares = 0;
   initial forever #5 clock_in = ~clock_in;
   scrs_board_straps scrs_board_straps_inst (.hold_in(hold), .code_in(code),
      .noise_in(noise), .pins_out(pins), .legal_out(legal),
      .pci_clock_needed_out(pci_need), .eth_fifo_max_out(eth_max));
   scrs_strap_select scrs_strap_select_inst (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .platform_ratio_strap_in(pins[7:4]), .core_ratio_strap_bit2_in(pins[3]),
      .core_ratio_strap_bit1_in(pins[2]), .core_ratio_strap_bit0_in(pins[1]),
      .security_ratio_strap_in(pins[0]), .platform_ratio_out(plat),
      .platform_reserved_out(pres), .core_ratio_half_out(core), .core_reserved_out(cres),
      .security_ratio_out(sec), .ratios_valid_out(vld), .mem_clock_tick_out(tick));
   function automatic logic [7:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng[7:0];
   endfunction : xs
   function automatic logic [7:0] plat_exp(int c);
      case (c)
         0: return 8'h10;
         3, 4, 5, 6, 8, 9, 10, 12: return 8'(c);
         default: return 8'h00;
      endcase
   endfunction : plat_exp
   function automatic logic [7:0] core_exp(int c);
      return c == 0 ? 8'h08 : (c > 2 ? 8'(c) : 8'h00);
   endfunction : core_exp
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task end_of_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   initial begin
      for (int i = 0; i < 16; i++) begin
         hold <= 1;
         rst_n_in <= 0;
         code <= {i[3:0], i[2:0], i[0]};
         repeat (16) @(posedge clock_in);
         chk(sec, 8'h03);
         rst_n_in <= 1;
         repeat (2) @(posedge clock_in);
         #1 chk(vld, 8'h00);
         @(posedge clock_in);
         hold <= 0;
         #1 chk(vld, 8'h01);
         t = 8'h00;
         repeat (6) begin
            @(posedge clock_in);
            noise <= xs();
            #1 t += tick;
         end
         chk(t, 8'h03);
         chk(plat, plat_exp(i));
         chk(pres, plat_exp(i) == 0);
         chk(core, core_exp(i % 8));
         chk(cres, core_exp(i % 8) == 0);
         chk(sec, i % 2 ? 8'h03 : 8'h02);
         chk(pci_need, 8'h00);
         $display("test %0d done legal %0d eth max %0d", i, legal, eth_max);
      end
      end_of_test();
   end
endmodule : strap_clock_ratio_select_tb_top
bind scrs_strap_select scrs_strap_assertions scrs_strap_assertions_inst (.*);
